// File: rtl/clkctl_pkg.sv
// package with register map, field layout, settings types and bus response codes for the input clock control block
// How it works
// - bypass bit 1 skips glitch-free reference mux
// - keep-on 0 powers down alt buffer once the reference is back on the main input
// - keep-on 1 keeps alt buffer on
// - 3-bit reference divider, 0 bypass, n+1
// - 5-bit feedback divider, 0 bypass, n+1
package clkctl_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_INPUT_CLOCK_CONTROL = 8'h33;
    localparam logic [7:0] IDX_SYNTH1_REF_DIV = 8'h34;
    localparam logic [7:0] IDX_SYNTH1_FB_DIV = 8'h35;
    localparam int ADDR_W = 12;
    localparam int BYPASS_BIT = 7;
    localparam int KEEP_ON_BIT = 2;
    localparam int ALT_GAIN_BIT = 1;
    localparam int MAIN_GAIN_BIT = 0;
    localparam int REF_DIV_W = 3;
    localparam int FB_DIV_W = 5;
    localparam int RSVD_LO = 3;
    localparam int RSVD_HI = 6;
    localparam logic [7:0] INPUT_CLOCK_CONTROL_RESET = 8'h03;
    localparam logic [7:0] SYNTH1_REF_DIV_RESET = 8'h00;
    localparam logic [7:0] SYNTH1_FB_DIV_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic ref_mux_bypass;
        logic keep_alt_osc_buffer_on;
        logic alt_input_gain;
        logic main_input_gain;
    } input_ctrl_t;

    typedef struct packed {
        logic ref_mux_enable;
        logic alt_osc_buffer_enable;
        logic alt_gain_max;
        logic main_gain_max;
        logic ref_div_bypass;
        logic [3:0] ref_div_value;
        logic fb_div_bypass;
        logic [5:0] fb_div_value;
    } clk_cfg_t;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction
endpackage

// File: rtl/div_decode.sv
// decoder from a divider field to bypass flag and divide value
module div_decode #(
    parameter int W = 3
) (
    input wire logic [W-1:0] field,
    output logic bypass,
    output logic [W:0] value
);
    // refuse field widths the decoder cannot serve at elaboration
    if (W < 1 || W > 8)
    begin
        $error("div_decode width out of range");
    end
    // zero bypasses, any n divides by n+1
    always_comb
    begin
        bypass = (field == '0);
        value = bypass ? {{W{1'b0}}, 1'b1} : ({1'b0, field} + {{W{1'b0}}, 1'b1});
    end
endmodule

// File: rtl/input_clock_ctrl.sv
// axi4-lite register block for input clock control and synthesizer 1 dividers
module input_clock_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [clkctl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [clkctl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_on_main,
    output clkctl_pkg::clk_cfg_t cfg
);
    import clkctl_pkg::*;

    typedef enum logic [1:0] {W_IDLE, W_RESP} wstate_t;

    logic [7:0] ctrl_q;
    logic [REF_DIV_W-1:0] rdiv_q;
    logic [FB_DIV_W-1:0] mdiv_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic aw_have_q;
    logic [7:0] wbyte_q;
    logic wstrb0_q;
    logic w_have_q;
    wstate_t wstate_q;
    logic alt_buf_on_q;
    logic rdiv_byp;
    logic mdiv_byp;
    logic [REF_DIV_W:0] rdiv_val;
    logic [FB_DIV_W:0] mdiv_val;
    logic do_write;
    logic [7:0] rd_byte;
    logic rd_hit;

    input_ctrl_t ictl;
    assign ictl = '{ref_mux_bypass: ctrl_q[BYPASS_BIT], keep_alt_osc_buffer_on: ctrl_q[KEEP_ON_BIT],
                    alt_input_gain: ctrl_q[ALT_GAIN_BIT], main_input_gain: ctrl_q[MAIN_GAIN_BIT]};

    function automatic logic [1:0] decode_reg(input logic [ADDR_W-1:0] a);
        if (a == byte_addr(IDX_INPUT_CLOCK_CONTROL))
            decode_reg = 2'h1;
        else if (a == byte_addr(IDX_SYNTH1_REF_DIV))
            decode_reg = 2'h2;
        else if (a == byte_addr(IDX_SYNTH1_FB_DIV))
            decode_reg = 2'h3;
        else
            decode_reg = 2'h0;
    endfunction

    // write address and data taken in either order, response after both
    assign do_write = aw_have_q && w_have_q && (wstate_q == W_IDLE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && wstate_q == W_IDLE;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (do_write)
                aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            wbyte_q <= '0;
            wstrb0_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_have_q && !s_axi_wready && wstate_q == W_IDLE;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wbyte_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            else if (do_write)
                w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wstate_q <= W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            case (wstate_q)
                W_IDLE:
                    if (do_write)
                    begin
                        wstate_q <= W_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (decode_reg(awaddr_q) == 2'h0) ? RESP_SLVERR : RESP_OKAY;
                    end
                W_RESP:
                    if (s_axi_bready)
                    begin
                        wstate_q <= W_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                default:
                    wstate_q <= W_IDLE;
            endcase
        end
    end

    // register storage; reserved bits 6:3 of the control register are writable
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= INPUT_CLOCK_CONTROL_RESET;
            rdiv_q <= SYNTH1_REF_DIV_RESET[REF_DIV_W-1:0];
            mdiv_q <= SYNTH1_FB_DIV_RESET[FB_DIV_W-1:0];
        end
        else if (do_write && wstrb0_q)
        begin
            if (decode_reg(awaddr_q) == 2'h1)
                ctrl_q <= wbyte_q;
            else if (decode_reg(awaddr_q) == 2'h2)
                rdiv_q <= wbyte_q[REF_DIV_W-1:0];
            else if (decode_reg(awaddr_q) == 2'h3)
                mdiv_q <= wbyte_q[FB_DIV_W-1:0];
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        if (decode_reg(s_axi_araddr) == 2'h1)
            rd_byte = ctrl_q;
        else if (decode_reg(s_axi_araddr) == 2'h2)
            rd_byte = {{(8-REF_DIV_W){1'b0}}, rdiv_q};
        else if (decode_reg(s_axi_araddr) == 2'h3)
            rd_byte = {{(8-FB_DIV_W){1'b0}}, mdiv_q};
        else
            rd_hit = 1'b0;
    end

    // read channel: one cycle to rvalid after arvalid and arready
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // alternate crystal buffer: off on return to main input unless kept on
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            alt_buf_on_q <= 1'b1;
        else if (!ref_on_main)
            alt_buf_on_q <= 1'b1;
        else if (ictl.keep_alt_osc_buffer_on)
            alt_buf_on_q <= 1'b1;
        else
            alt_buf_on_q <= 1'b0;
    end

    div_decode #(.W(REF_DIV_W)) u_rdiv (.field(rdiv_q), .bypass(rdiv_byp), .value(rdiv_val));
    div_decode #(.W(FB_DIV_W)) u_mdiv (.field(mdiv_q), .bypass(mdiv_byp), .value(mdiv_val));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg <= '0;
        else
        begin
            cfg.ref_mux_enable <= !ictl.ref_mux_bypass;
            cfg.alt_osc_buffer_enable <= alt_buf_on_q;
            cfg.alt_gain_max <= ictl.alt_input_gain;
            cfg.main_gain_max <= ictl.main_input_gain;
            cfg.ref_div_bypass <= rdiv_byp;
            cfg.ref_div_value <= rdiv_val;
            cfg.fb_div_bypass <= mdiv_byp;
            cfg.fb_div_value <= mdiv_val;
        end
    end
endmodule

// File: verification/input_clock_ctrl_assertions.sv
// assertions on the ports of the input clock control block
module input_clock_ctrl_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_on_main,
    input wire clkctl_pkg::clk_cfg_t cfg
);
    import clkctl_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    clk_cfg_t m;
    // all settings except the alt buffer, which also follows the input selection
    always_comb
    begin
        m = cfg;
        m.alt_osc_buffer_enable = 1'h0;
    end
    a_ref_div_map: assert property ($past(aresetn) |->
        cfg.ref_div_bypass == (cfg.ref_div_value == 4'h1) && cfg.ref_div_value inside {[1:8]}) else $error("ref div");
    a_fb_div_map: assert property ($past(aresetn) |->
        cfg.fb_div_bypass == (cfg.fb_div_value == 6'h1) && cfg.fb_div_value inside {[1:32]}) else $error("fb div");
    a_alt_stays_on: assert property (!ref_on_main [*4] |-> cfg.alt_osc_buffer_enable) else $error("alt off");
    a_alt_off_main: assert property ($fell(cfg.alt_osc_buffer_enable) |->
        $past(ref_on_main) || $past(ref_on_main, 2) || $past(ref_on_main, 3)) else $error("alt fell");
    a_cfg_write_only: assert property ($past(aresetn, 2) && $changed(m) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("cfg moved");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("b dropped");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("r dropped");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata high");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("r late");
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_ref_max: cover property (cfg.ref_div_value == 4'h8);
    c_fb_max: cover property (cfg.fb_div_value == 6'h20);
endmodule
bind input_clock_ctrl input_clock_ctrl_checker chk_u (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ref_on_main, .cfg);

// File: verification/input_clock_ctrl_tb.sv
// self-checking bench for the input clock control register block
module input_clock_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import clkctl_pkg::*;
    int n_fail = 0, checks_done = 0, cyc = 0;
    logic [31:0] seed = 32'h40C9;
    logic [7:0] regs [4] = '{8'h03, 8'h00, 8'h00, 8'h00};
    logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, ref_on_main = 1'h1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    clk_cfg_t cfg;
    input_clock_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_on_main, .cfg);
    initial forever #2.5 aclk = ~aclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic clk_cfg_t ecfg(input logic on);
        clk_cfg_t c;
        c.ref_mux_enable = !regs[0][7];
        c.alt_osc_buffer_enable = !on || regs[0][2];
        c.alt_gain_max = regs[0][1];
        c.main_gain_max = regs[0][0];
        c.ref_div_bypass = regs[1][2:0] == 3'h0;
        c.ref_div_value = {1'h0, regs[1][2:0]} + 4'h1;
        c.fb_div_bypass = regs[2][4:0] == 5'h0;
        c.fb_div_value = {1'h0, regs[2][4:0]} + 6'h1;
        return c;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one register access pair: write, then read back, then check the decoded settings
    task automatic op(input int i, input logic [31:0] d, input logic [3:0] s, input logic on);
        logic [11:0] a;
        logic ta, tw, hs;
        a = 12'({IDX_INPUT_CLOCK_CONTROL + 8'(i), 2'h0});
        ta = 0;
        tw = 0;
        @(posedge aclk);
        ref_on_main <= on;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1'h1;
        while (!(ta && tw))
        begin
            @(posedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end
        do
        begin
            @(posedge aclk);
            hs = s_axi_bvalid === 1'h1 && s_axi_bready;
            s_axi_bready <= !hs;
        end while (!hs);
        chk(32'(s_axi_bresp), i == 3 ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
        if (i < 3 && s[0])
            regs[i] = d[7:0] & (i == 0 ? 8'hFF : i == 1 ? 8'h07 : 8'h1F);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            hs = s_axi_arready;
            s_axi_arvalid <= !hs;
        end while (!hs);
        do
        begin
            @(posedge aclk);
            hs = s_axi_rvalid === 1'h1 && s_axi_rready;
            s_axi_rready <= !hs;
        end while (!hs);
        chk(s_axi_rdata, {24'h0, regs[i]});
        chk(32'(s_axi_rresp), i == 3 ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
        chk(32'(cfg), 32'(ecfg(on)));
    endtask
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        logic [15:0] cd [8];
        cd = '{16'h0080, 16'h007C, 16'h01FF, 16'h02FF, 16'h0201, 16'h0100, 16'h0000, 16'h0355};
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 4; i++) op(i, 32'hFFFFFFFF, 4'h0, 1'h1);
        $display("reset values test done");
        for (int k = 0; k < 8; k++) op(int'(cd[k][15:8]), {24'h0, cd[k][7:0]}, 4'h1, !k[0]);
        $display("corner test done");
        for (int k = 0; k < 40; k++) op(int'(rnd() % 4), rnd(), 4'(rnd()), 1'(rnd()));
        $display("random test done");
        // reset in mid-run must bring every register back to its reset value
        @(posedge aclk);
        aresetn <= 0;
        ref_on_main <= 1'h1;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        regs = '{8'h03, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) op(i, 32'hFFFFFFFF, 4'h0, 1'h1);
        $display("mid-run reset test done");
        summarize();
    end
endmodule
